// ==== hw/dws_pkg.sv ====
// shared constants, types and state layout of the waveform synthesis core
package dws_pkg;
	localparam int unsigned SAMPLE_HZ        = 50_000_000;
	localparam int unsigned ARB_MAX_HZ       = 3_000_000;
	localparam int unsigned PULSE_CLK_MIN_HZ = 95_000_000;
	localparam int unsigned PULSE_CLK_MAX_HZ = 100_000_000;
	localparam int unsigned PULSE_CLK_MULT   = 5;
	localparam int unsigned ACC_W            = 64;
	localparam int unsigned CODE_W           = 14;
	localparam int unsigned STD_AW           = 14;
	localparam int unsigned ARB_AW           = 13;
	localparam int unsigned STD_DEPTH        = 16384;
	localparam int unsigned ARB_DEPTH        = 8192;
	localparam int unsigned FIFO_DEPTH       = 8;
	localparam int unsigned ADDR_W           = 8;
	localparam logic [127:0] ARB_MAX_STEP_W =
		((128'h1 << ACC_W) * 128'(ARB_MAX_HZ)) / 128'(SAMPLE_HZ);
	localparam logic [63:0] ARB_MAX_STEP = ARB_MAX_STEP_W[63:0];
	localparam logic [13:0] CODE_MID     = 14'h2000;
	localparam logic [13:0] ARB_LEN_MAX  = 14'h2000;
	localparam logic [13:0] ARB_LEN_MIN  = 14'h0001;
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STEP_LO  = 8'h04;
	localparam logic [7:0] OFF_STEP_HI  = 8'h08;
	localparam logic [7:0] OFF_THRESH   = 8'h0C;
	localparam logic [7:0] OFF_PERIOD   = 8'h10;
	localparam logic [7:0] OFF_WIDTH    = 8'h14;
	localparam logic [7:0] OFF_EDGE     = 8'h18;
	localparam logic [7:0] OFF_ARB_LEN  = 8'h1C;
	localparam logic [7:0] OFF_ARB_DATA = 8'h20;
	localparam logic [7:0] OFF_STD_ADDR = 8'h24;
	localparam logic [7:0] OFF_STD_DATA = 8'h28;
	localparam logic [7:0] OFF_STATUS   = 8'h2C;
	localparam logic [7:0] OFF_PHASE_HI = 8'h30;
	localparam int unsigned CTRL_INTERP_BIT = 3;
	localparam int unsigned STAT_FULL_BIT   = 16;
	localparam int unsigned STAT_SQ_BIT     = 17;
	localparam int unsigned STAT_PULSE_BIT  = 18;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		MODE_SINE   = 3'h0,
		MODE_SQUARE = 3'h1,
		MODE_STD    = 3'h3,
		MODE_ARB    = 3'h2,
		MODE_PULSE  = 3'h6
	} dws_mode_e;
	typedef struct packed {
		logic [13:0] code;
		logic        ellip;
		logic        square;
		logic        pulse;
		logic        pulse_path;
	} dws_out_s;
	typedef struct packed {
		logic [63:0] acc;
		logic [63:0] step;
		dws_mode_e   mode;
		logic        interp;
		logic [13:0] thresh;
		logic [31:0] period;
		logic [31:0] width;
		logic [15:0] edge_t;
		logic [13:0] arb_len;
		logic [12:0] wr_idx;
		logic [13:0] std_addr;
		logic [31:0] pcnt;
		dws_out_s    out;
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} dws_state_s;
	typedef struct packed {
		logic [3:0] rd;
		logic [3:0] wr;
	} dws_fifo_s;
endpackage

// ==== hw/dws_synth.sv ====
// waveform synthesis core with register slave and point buffer
// How it works
// - one sample to the DAC each clock
// - memory playback except pulse, pulse from counter
// - standard memory 16384 words, user memory 8192
// - each sample is a 14-bit amplitude code
// - memory spans exactly one waveform cycle
// - short user waveforms repeated or interpolated
// - accumulator adds phase step every clock
// - accumulator is 64 bits wide
// - top 13 or 14 bits address memory
// - new step never loads the phase
// - elliptic path only for continuous sine
// - square is sine compared with threshold
// - pulse period and width from cycle counts
// - pulse counter steps once per sample clock
// - period, width, edge time set independently
// - user waveforms hold at most 8192 points
// - user waveform rate capped at 3 MHz
`timescale 1ns/1ns
module dws_fifo #(
	parameter int unsigned W = 14,
	parameter int unsigned D = 8
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int unsigned PW = $clog2(D) + 1;
	typedef struct packed {
		logic [PW-1:0] rd;
		logic [PW-1:0] wr;
	} dws_fptr_s;
	dws_fptr_s s_r;
	dws_fptr_s s_nxt;
	logic [W-1:0] mem [D];
	logic         full;
	logic         empty;
	assign empty     = s_r.rd == s_r.wr;
	assign full      = (s_r.rd[PW-2:0] == s_r.wr[PW-2:0]) && !empty;
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[s_r.rd[PW-2:0]];
	always_comb begin
		s_nxt = s_r;
		if (in_valid && !full) begin
			s_nxt.wr = s_r.wr + 1'b1;
		end
		if (out_ready && !empty) begin
			s_nxt.rd = s_r.rd + 1'b1;
		end
	end
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (in_valid && !full) begin
			mem[s_r.wr[PW-2:0]] <= in_data;
		end
	end
endmodule

module dws_synth #(
	parameter int unsigned FIFO_D = dws_pkg::FIFO_DEPTH
) (
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic [dws_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]                 s_axi_awprot,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [dws_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]                 s_axi_arprot,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	output dws_pkg::dws_out_s               wave_out,
	output logic [15:0]                     edge_code
);
	dws_pkg::dws_state_s s_r;
	dws_pkg::dws_state_s s_nxt;
	logic [13:0] std_mem [dws_pkg::STD_DEPTH];
	logic [13:0] arb_mem [dws_pkg::ARB_DEPTH];
	logic        do_wr;
	logic        std_we;
	logic        f_in_valid;
	logic        f_in_ready;
	logic        f_out_valid;
	logic        f_out_ready;
	logic [13:0] f_out_data;
	logic [63:0] eff_step;
	logic [13:0] std_smp;
	logic [12:0] a13;
	logic [26:0] prod;
	logic [12:0] idx;
	logic [12:0] nidx;
	logic [12:0] frac;
	logic [13:0] p0;
	logic [13:0] p1;
	logic signed [14:0] diff;
	logic signed [28:0] mul;
	logic [13:0] arb_smp;
	logic [31:0] rd_val;
	logic        rd_ok;

	function automatic logic [31:0] dws_merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic dws_wmap(input logic [7:0] a);
		return a <= dws_pkg::OFF_STD_DATA;
	endfunction

	assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
	assign s_axi_wready  = !s_r.w_got && !s_r.bvalid;
	assign s_axi_bvalid  = s_r.bvalid;
	assign s_axi_bresp   = s_r.bresp;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_rvalid  = s_r.rvalid;
	assign s_axi_rdata   = s_r.rdata;
	assign s_axi_rresp   = s_r.rresp;
	assign wave_out      = s_r.out;
	assign edge_code     = s_r.edge_t;

	// point stream stalls while user waveform plays, pressing back on the bus
	assign f_in_valid  = s_r.aw_got && s_r.w_got && !s_r.bvalid
		&& s_r.awaddr == dws_pkg::OFF_ARB_DATA;
	assign f_out_ready = s_r.mode != dws_pkg::MODE_ARB;
	assign do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid
		&& (s_r.awaddr != dws_pkg::OFF_ARB_DATA || f_in_ready);
	assign std_we = do_wr && s_r.awaddr == dws_pkg::OFF_STD_DATA;

	dws_fifo #(.W(dws_pkg::CODE_W), .D(FIFO_D)) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (f_in_valid),
		.in_ready  (f_in_ready),
		.in_data   (s_r.wdata[13:0]),
		.out_valid (f_out_valid),
		.out_ready (f_out_ready),
		.out_data  (f_out_data)
	);

	// user waveform rate ceiling
	assign eff_step = (s_r.mode == dws_pkg::MODE_ARB && s_r.step > dws_pkg::ARB_MAX_STEP)
		? dws_pkg::ARB_MAX_STEP : s_r.step;
	assign std_smp = std_mem[s_r.acc[63 -: dws_pkg::STD_AW]];
	assign a13     = s_r.acc[63 -: dws_pkg::ARB_AW];
	// stretch len points over the 8192 phase slots
	assign prod = {14'h0, a13} * {13'h0, s_r.arb_len};
	assign idx  = prod[25:13];
	assign frac = prod[12:0];
	assign nidx = ({1'b0, idx} + 14'h1 == s_r.arb_len) ? 13'h0 : idx + 13'h1;
	assign p0   = arb_mem[idx];
	assign p1   = arb_mem[nidx];
	assign diff = $signed({1'b0, p1}) - $signed({1'b0, p0});
	assign mul  = diff * $signed({1'b0, frac});
	assign arb_smp = s_r.interp ? p0 + 14'(mul >>> 13) : p0;

	always_comb begin
		rd_ok = 1'b1;
		case (s_axi_araddr)
			dws_pkg::OFF_CTRL:     rd_val = {28'h0, s_r.interp, s_r.mode};
			dws_pkg::OFF_STEP_LO:  rd_val = s_r.step[31:0];
			dws_pkg::OFF_STEP_HI:  rd_val = s_r.step[63:32];
			dws_pkg::OFF_THRESH:   rd_val = {18'h0, s_r.thresh};
			dws_pkg::OFF_PERIOD:   rd_val = s_r.period;
			dws_pkg::OFF_WIDTH:    rd_val = s_r.width;
			dws_pkg::OFF_EDGE:     rd_val = {16'h0, s_r.edge_t};
			dws_pkg::OFF_ARB_LEN:  rd_val = {18'h0, s_r.arb_len};
			dws_pkg::OFF_ARB_DATA: rd_val = {19'h0, s_r.wr_idx};
			dws_pkg::OFF_STD_ADDR: rd_val = {18'h0, s_r.std_addr};
			dws_pkg::OFF_STD_DATA: rd_val = 32'h0;
			dws_pkg::OFF_STATUS: begin
				rd_val = {18'h0, s_r.acc[63 -: dws_pkg::STD_AW]};
				rd_val[dws_pkg::STAT_FULL_BIT]  = !f_in_ready;
				rd_val[dws_pkg::STAT_SQ_BIT]    = s_r.out.square;
				rd_val[dws_pkg::STAT_PULSE_BIT] = s_r.out.pulse;
			end
			dws_pkg::OFF_PHASE_HI: rd_val = s_r.acc[63:32];
			default: begin
				rd_val = 32'h0;
				rd_ok  = 1'b0;
			end
		endcase
	end

	always_comb begin
		s_nxt = s_r;
		// free-running wrap, step changes rate only
		s_nxt.acc = s_r.acc + eff_step;
		// output sample, one per clock
		case (s_r.mode)
			dws_pkg::MODE_PULSE: s_nxt.out.code = dws_pkg::CODE_MID;
			dws_pkg::MODE_ARB:   s_nxt.out.code = arb_smp;
			default:             s_nxt.out.code = std_smp;
		endcase
		s_nxt.out.ellip      = s_r.mode == dws_pkg::MODE_SINE;
		s_nxt.out.square     = std_smp >= s_r.thresh;
		s_nxt.out.pulse_path = s_r.mode == dws_pkg::MODE_PULSE;
		// pulse counter, period and width are separate counts
		if (s_r.mode == dws_pkg::MODE_PULSE) begin
			s_nxt.pcnt = (s_r.pcnt + 32'h1 >= s_r.period) ? 32'h0 : s_r.pcnt + 32'h1;
			s_nxt.out.pulse = s_r.pcnt < s_r.width;
		end else begin
			s_nxt.pcnt      = 32'h0;
			s_nxt.out.pulse = 1'b0;
		end
		if (f_out_valid && f_out_ready) begin
			s_nxt.wr_idx = s_r.wr_idx + 13'h1;
		end
		// write channel
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = dws_wmap(s_r.awaddr) ? dws_pkg::RESP_OKAY : dws_pkg::RESP_SLVERR;
			case (s_r.awaddr)
				dws_pkg::OFF_CTRL: begin
					s_nxt.mode = dws_pkg::dws_mode_e'(s_r.wdata[2:0]);
					s_nxt.interp = s_r.wdata[dws_pkg::CTRL_INTERP_BIT];
				end
				dws_pkg::OFF_STEP_LO:
					s_nxt.step[31:0] = dws_merge(s_r.step[31:0], s_r.wdata, s_r.wstrb);
				dws_pkg::OFF_STEP_HI:
					s_nxt.step[63:32] = dws_merge(s_r.step[63:32], s_r.wdata, s_r.wstrb);
				dws_pkg::OFF_THRESH: s_nxt.thresh = s_r.wdata[13:0];
				dws_pkg::OFF_PERIOD:
					s_nxt.period = dws_merge(s_r.period, s_r.wdata, s_r.wstrb);
				dws_pkg::OFF_WIDTH:
					s_nxt.width = dws_merge(s_r.width, s_r.wdata, s_r.wstrb);
				dws_pkg::OFF_EDGE: s_nxt.edge_t = s_r.wdata[15:0];
				dws_pkg::OFF_ARB_LEN: begin
					s_nxt.wr_idx = 13'h0;
					if (s_r.wdata > 32'(dws_pkg::ARB_LEN_MAX)) begin
						s_nxt.arb_len = dws_pkg::ARB_LEN_MAX;
					end else if (s_r.wdata[13:0] == 14'h0) begin
						s_nxt.arb_len = dws_pkg::ARB_LEN_MIN;
					end else begin
						s_nxt.arb_len = s_r.wdata[13:0];
					end
				end
				dws_pkg::OFF_STD_ADDR: s_nxt.std_addr = s_r.wdata[13:0];
				dws_pkg::OFF_STD_DATA: s_nxt.std_addr = s_r.std_addr + 14'h1;
				default: s_nxt.mode = s_r.mode;
			endcase
		end
		// read channel
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_r.rvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = rd_val;
			s_nxt.rresp  = rd_ok ? dws_pkg::RESP_OKAY : dws_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_r         <= '0;
			s_r.arb_len <= dws_pkg::ARB_LEN_MAX;
			s_r.out.code <= dws_pkg::CODE_MID;
			s_r.out.ellip <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (std_we) begin
			std_mem[s_r.std_addr] <= s_r.wdata[13:0];
		end
		if (f_out_valid && f_out_ready) begin
			arb_mem[s_r.wr_idx] <= f_out_data;
		end
	end
endmodule

// ==== verif/dws_dac_model.sv ====
// converter side model: latches each sample and counts pulse-high cycles
`timescale 1ns/1ns
module dws_dac_model (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire dws_pkg::dws_out_s wave,
	output logic [13:0]            level,
	output int unsigned            hi_count
);
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			level <= dws_pkg::CODE_MID;
			hi_count <= 0;
		end else begin
			level <= wave.code;
			if (wave.pulse_path && wave.pulse) begin
				hi_count <= hi_count + 1;
			end
		end
	end
endmodule

// ==== verif/dws_synth_chk.sv ====
// port-level assertions for the synthesis core
`timescale 1ns/1ns
module dws_synth_chk (
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bready,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire dws_pkg::dws_out_s wave_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read valid stuck");
	a_bad_zero: assert property (s_axi_rvalid && s_axi_rresp == dws_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response stuck");
	a_ellip_sine: assert property (wave_out.ellip |-> !wave_out.pulse_path)
		else $error("elliptic path outside sine");
	a_pulse_mid: assert property (wave_out.pulse_path [*2] |-> wave_out.code == dws_pkg::CODE_MID)
		else $error("memory sample during pulse");
	a_pulse_gate: assert property (!wave_out.pulse_path [*2] |-> !wave_out.pulse)
		else $error("pulse outside pulse mode");
endmodule
bind dws_synth dws_synth_chk i_chk (.clk_sys(clk_sys), .rst(rst), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .wave_out(wave_out));

// ==== verif/dws_synth_test.sv ====
// register-driven bench for the synthesis core
`timescale 1ns/1ns
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dws_synth_test;
	logic              clk_sys = 1'b0;
	logic              rst = 1'b1;
	logic [7:0]        awaddr = 8'h00;
	logic [7:0]        araddr = 8'h00;
	logic [31:0]       wdata = 32'h0;
	logic              awvalid = 1'b0;
	logic              wvalid = 1'b0;
	logic              bready = 1'b0;
	logic              arvalid = 1'b0;
	logic              rready = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, r;
	logic [31:0]       rdata, d, p1;
	logic [15:0]       edge_code;
	dws_pkg::dws_out_s wave_out;
	int unsigned       hi_count, c0;
	int                fail_count = 0;
	int                total_checks = 0;
	dws_synth i_dut (.clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .wave_out(wave_out), .edge_code(edge_code));
	dws_dac_model i_dac (.clk_sys(clk_sys), .rst(rst), .wave(wave_out), .level(), .hi_count(hi_count));
	task automatic test_done();
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#2000000;
		fail_count++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		`CHK(wave_out.code, dws_pkg::CODE_MID)
		`CHK(edge_code, 16'h0000)
		rst <= 1'b0;
		wr(dws_pkg::OFF_STD_ADDR, 32'h0);
		wr(dws_pkg::OFF_STD_DATA, 32'h1000);
		wr(dws_pkg::OFF_THRESH, 32'h0FFF);
		wr(dws_pkg::OFF_CTRL, 32'h1);
		settle(3);
		`CHK(wave_out.square, 1'b1)
		rd(dws_pkg::OFF_STATUS);
		`CHK(d[18:0], 19'h20000)
		wr(dws_pkg::OFF_THRESH, 32'h1001);
		settle(3);
		`CHK(wave_out.square, 1'b0)
		wr(dws_pkg::OFF_CTRL, 32'h0);
		settle(3);
		`CHK(wave_out.code, 14'h1000)
		`CHK(wave_out.ellip, 1'b1)
		wr(dws_pkg::OFF_CTRL, 32'h3);
		settle(3);
		`CHK(wave_out.ellip, 1'b0)
		wr(dws_pkg::OFF_ARB_LEN, 32'h2);
		wr(dws_pkg::OFF_ARB_DATA, 32'h0100);
		wr(dws_pkg::OFF_ARB_DATA, 32'h0200);
		settle(10);
		wr(dws_pkg::OFF_CTRL, 32'h2);
		settle(3);
		`CHK(wave_out.code, 14'h0100)
		wr(dws_pkg::OFF_CTRL, 32'hA);
		wr(dws_pkg::OFF_STEP_HI, 32'h0080_0000);
		wr(dws_pkg::OFF_STEP_HI, 32'h0);
		rd(dws_pkg::OFF_PHASE_HI);
		settle(2);
		`CHK(wave_out.code, 14'h100 + 14'((32'h100 * {d[31:19], 1'b0}) >> 13))
		wr(dws_pkg::OFF_ARB_LEN, 32'h8);
		for (int i = 0; i < 8; i++) wr(dws_pkg::OFF_ARB_DATA, i);
		rd(dws_pkg::OFF_STATUS);
		`CHK(d[16], 1'b1)
		wr(dws_pkg::OFF_CTRL, 32'h0);
		settle(20);
		rd(dws_pkg::OFF_STATUS);
		`CHK(d[16], 1'b0)
		wr(dws_pkg::OFF_ARB_LEN, 32'h3000);
		rd(dws_pkg::OFF_ARB_LEN);
		`CHK(d[13:0], dws_pkg::ARB_LEN_MAX)
		wr(dws_pkg::OFF_ARB_LEN, 32'h0);
		rd(dws_pkg::OFF_ARB_LEN);
		`CHK(d[13:0], dws_pkg::ARB_LEN_MIN)
		wr(dws_pkg::OFF_PERIOD, 32'd10);
		wr(dws_pkg::OFF_WIDTH, 32'd3);
		wr(dws_pkg::OFF_CTRL, 32'h6);
		settle(3);
		`CHK(wave_out.pulse_path, 1'b1)
		c0 = hi_count;
		settle(100);
		`CHK(hi_count - c0, 32'd30)
		wr(dws_pkg::OFF_EDGE, 32'h5);
		settle(2);
		`CHK(edge_code, 16'h0005)
		c0 = hi_count;
		settle(100);
		`CHK(hi_count - c0, 32'd30)
		wr(dws_pkg::OFF_CTRL, 32'h0);
		wr(dws_pkg::OFF_STEP_HI, 32'h1);
		wr(dws_pkg::OFF_STEP_HI, 32'h0);
		rd(dws_pkg::OFF_PHASE_HI);
		p1 = d;
		rd(dws_pkg::OFF_PHASE_HI);
		`CHK(d, p1)
		`CHK(p1 != 0, 1'b1)
		wr(dws_pkg::OFF_STEP_LO, 32'h8000_0000);
		rd(dws_pkg::OFF_PHASE_HI);
		`CHK(d > p1 && d - p1 < 32'd40, 1'b1)
		wr(dws_pkg::OFF_STEP_LO, 32'h0);
		wr(dws_pkg::OFF_STEP_HI, 32'h8000_0000);
		rd(dws_pkg::OFF_PHASE_HI);
		p1 = d;
		rd(dws_pkg::OFF_PHASE_HI);
		`CHK(d[30:0], p1[30:0])
		wr(dws_pkg::OFF_CTRL, 32'h2);
		wr(dws_pkg::OFF_STEP_HI, 32'hFFFF_FFFF);
		rd(dws_pkg::OFF_PHASE_HI);
		p1 = d;
		rd(dws_pkg::OFF_PHASE_HI);
		`CHK(d - p1 - 32'(3 * dws_pkg::ARB_MAX_STEP[63:32]) <= 32'd3, 1'b1)
		rd(8'h3C);
		`CHK(r, dws_pkg::RESP_SLVERR)
		`CHK(d, 32'h0)
		wr(8'h40, 32'h1);
		`CHK(r, dws_pkg::RESP_SLVERR)
		wr(dws_pkg::OFF_STATUS, 32'h1);
		`CHK(r, dws_pkg::RESP_SLVERR)
		test_done();
	end
endmodule
